// ==== core/sir_pkg.sv ====
/*
 * Constants for the socket identity and status register pair.
 * Assumes a byte-wide register port with the socket window offsets.
 */
package sir_pkg;
    // Register offsets in the socket window
    localparam logic [11:0] ID_REV_OFFSET = 12'h800;
    localparam logic [11:0] IF_STATUS_OFFSET = 12'h801;
    // Identity register fields
    localparam int INTERFACE_KIND_LSB = 6;
    localparam logic [1:0] INTERFACE_KIND_VALUE = 2'h2;
    localparam int EMU_SPARE_LSB = 4;
    localparam logic [1:0] EMU_SPARE_RESET = 2'h0;
    // Reset revision code; value is arbitrary
    localparam logic [3:0] LEGACY_REVISION_RESET = 4'h3;
    localparam logic [3:0] LEGACY_REVISION_OLD_MODE = 4'h2;
    // Status register field positions
    localparam int ST_POWER_BIT = 6;
    localparam int ST_READY_BIT = 5;
    localparam int ST_WP_BIT = 4;
    localparam int ST_DETECT2_BIT = 3;
    localparam int ST_DETECT1_BIT = 2;
    // Synchroniser depth
    localparam int SYNC_STAGES = 2;
    typedef enum logic {
        SIR_CARD_MEMORY,
        SIR_CARD_IO
    } sir_card_kind_type;
endpackage

// ==== core/sir_pins_if.sv ====
/*
 * Interface carrying raw and synchronised card pin levels between modules.
 * Assumes a single host clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
interface sir_pins_if;
    logic [5:0] raw;
    logic [5:0] sync;
    modport sink (input raw, output sync);
    modport source (output raw, input sync);
endinterface
`default_nettype wire

// ==== core/sir_sync.sv ====
/*
 * Two-stage synchroniser for the six card pin inputs.
 * Assumes pins are asynchronous to the host clock.
 */
`timescale 1ns/100ps
`default_nettype none
module sir_sync (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Pin bundle
    sir_pins_if.sink pins
);
    logic [5:0] meta_r;
    logic [5:0] meta_nxt;
    logic [5:0] sync_r;
    logic [5:0] sync_nxt;

    // Second stage only reads the first
    always_comb begin
        meta_nxt = pins.raw;
        sync_nxt = meta_r;
    end

    // Register the stages
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_r <= 6'h00;
            sync_r <= 6'h00;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign pins.sync = sync_r;
endmodule
`default_nettype wire

// ==== core/sir_regs.sv ====
/*
 * Socket identification/revision and interface status registers.
 * Assumes a byte-wide synchronous register port on the host clock,
 * a global reset on i_rstn, and a bus reset that only clears
 * registers not held across it.
 */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Identity bits 7:6 read fixed 10b
// - Bits 5:4 plain read/write storage
// - Bits 3:0 revision code, reset default
// - Revision 0010b selects older emulation mode
// - Write lock makes identity register read-only
// - Identity cleared by global reset only
// - Status read-only, bit 7 reads zero
// - Bit 6 shows socket power on
// - Bit 5 follows card ready
// - Bit 4 follows write protect through the synchroniser, not inverted
// - Bit 3 is inverted detect pin 2
// - Bit 2 is inverted detect pin 1
// - Memory card: bits 1:0 battery pins
// - I/O card: speaker and status change
// - After reset upper bits zero, lower pins
module sir_regs (
    // Clock and global reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Bus reset, leaves identity untouched
    input wire logic i_bus_rstn,
    // Register port
    input wire logic i_reg_sel,
    input wire logic i_reg_wr,
    input wire logic [11:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Socket controls from other registers
    input wire logic i_subsystem_write_lock,
    input wire logic i_socket_power_on,
    input wire logic i_card_is_io,
    // Card pins
    input wire logic i_ready_pin,
    input wire logic i_card_write_protect_pin,
    input wire logic i_detect_pin_1,
    input wire logic i_detect_pin_2,
    input wire logic i_battery_pin_1,
    input wire logic i_battery_pin_2,
    input wire logic i_speaker_out_pin,
    input wire logic i_status_change_pin,
    // Mode outputs
    output logic o_legacy_mode,
    output logic [3:0] o_legacy_revision
);
    sir_pins_if pins ();

    logic [1:0] emu_spare_r;
    logic [1:0] emu_spare_nxt;
    logic [3:0] legacy_revision_r;
    logic [3:0] legacy_revision_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [7:0] status_byte;
    sir_pkg::sir_card_kind_type card_kind;

    // Address match helper
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] offset);
        hit = (addr == offset);
    endfunction

    // Battery pins for memory cards, speaker/status pins for I/O cards
    assign card_kind = i_card_is_io ? sir_pkg::SIR_CARD_IO : sir_pkg::SIR_CARD_MEMORY;
    assign pins.raw = (card_kind == sir_pkg::SIR_CARD_IO) ?
        {i_ready_pin, i_card_write_protect_pin, i_detect_pin_2, i_detect_pin_1,
         i_speaker_out_pin, i_status_change_pin} :
        {i_ready_pin, i_card_write_protect_pin, i_detect_pin_2, i_detect_pin_1,
         i_battery_pin_2, i_battery_pin_1};

    sir_sync u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .pins(pins)
    );

    // Status byte from power state and synchronised pins
    always_comb begin
        status_byte = 8'h00;
        status_byte[sir_pkg::ST_POWER_BIT] = i_socket_power_on;
        status_byte[sir_pkg::ST_READY_BIT] = pins.sync[5];
        status_byte[sir_pkg::ST_WP_BIT] = pins.sync[4];
        status_byte[sir_pkg::ST_DETECT2_BIT] = ~pins.sync[3];
        status_byte[sir_pkg::ST_DETECT1_BIT] = ~pins.sync[2];
        status_byte[1:0] = pins.sync[1:0];
    end

    // Identity writes, blocked by the lock; status writes ignored
    always_comb begin
        emu_spare_nxt = emu_spare_r;
        legacy_revision_nxt = legacy_revision_r;
        if (i_reg_sel && i_reg_wr && !i_subsystem_write_lock) begin
            if (hit(i_reg_addr, sir_pkg::ID_REV_OFFSET)) begin
                emu_spare_nxt = i_reg_wdata[5:4];
                legacy_revision_nxt = i_reg_wdata[3:0];
            end
        end
    end

    // Identity storage on global reset only
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            emu_spare_r <= sir_pkg::EMU_SPARE_RESET;
            legacy_revision_r <= sir_pkg::LEGACY_REVISION_RESET;
        end else begin
            emu_spare_r <= emu_spare_nxt;
            legacy_revision_r <= legacy_revision_nxt;
        end
    end

    // Read data, unmapped addresses read zero
    always_comb begin
        rdata_nxt = 8'h00;
        rvalid_nxt = i_reg_sel && !i_reg_wr;
        if (i_reg_sel && !i_reg_wr) begin
            if (hit(i_reg_addr, sir_pkg::ID_REV_OFFSET)) begin
                rdata_nxt = {sir_pkg::INTERFACE_KIND_VALUE, emu_spare_r,
                             legacy_revision_r};
            end else if (hit(i_reg_addr, sir_pkg::IF_STATUS_OFFSET)) begin
                rdata_nxt = status_byte;
            end
        end
        if (!i_bus_rstn) begin
            rvalid_nxt = 1'b0;
        end
    end

    // Read port registers
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_reg_rvalid = rvalid_r;
    assign o_legacy_revision = legacy_revision_r;
    assign o_legacy_mode = (legacy_revision_r == sir_pkg::LEGACY_REVISION_OLD_MODE);
endmodule
`default_nettype wire

// ==== dv/sir_regs_monitor.sv ====
/* Assertions on the socket identity and status register port.
   Assumes the sir_regs ports and pins held steady around status reads. */
`timescale 1ns/100ps
`default_nettype none
module sir_regs_monitor (
    // Clock and resets
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_bus_rstn,
    // Register port
    input wire logic i_reg_sel,
    input wire logic i_reg_wr,
    input wire logic [11:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    // Controls, pins and mode
    input wire logic i_subsystem_write_lock,
    input wire logic i_socket_power_on,
    input wire logic i_ready_pin,
    input wire logic i_detect_pin_2,
    input wire logic o_legacy_mode,
    input wire logic [3:0] o_legacy_revision
);
    // One clock domain for all checks
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    property p_kind;
        o_reg_rvalid && $past(i_reg_addr) == 12'h800 |-> o_reg_rdata[7:6] == 2'h2;
    endproperty
    a_kind: assert property (p_kind) else $error("kind field wrong");
    property p_zero;
        o_reg_rvalid && $past(i_reg_addr) == 12'h801 |-> !o_reg_rdata[7];
    endproperty
    a_zero: assert property (p_zero) else $error("status top bit set");
    property p_pwr;
        o_reg_rvalid && $past(i_reg_addr) == 12'h801 |-> o_reg_rdata[6] == $past(i_socket_power_on);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power bit wrong");
    property p_rdy;
        o_reg_rvalid && $past(i_reg_addr) == 12'h801 |-> o_reg_rdata[5] == $past(i_ready_pin, 3);
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready bit wrong");
    property p_cd2;
        o_reg_rvalid && $past(i_reg_addr) == 12'h801 |-> o_reg_rdata[3] != $past(i_detect_pin_2, 3);
    endproperty
    a_cd2: assert property (p_cd2) else $error("detect bit wrong");
    property p_wr;
        i_reg_sel && i_reg_wr && !i_subsystem_write_lock && i_reg_addr == 12'h800
        |=> {4'h0, o_legacy_revision} == ($past(i_reg_wdata) & 8'h0f)
        && o_legacy_mode == (o_legacy_revision == 4'h2);
    endproperty
    a_wr: assert property (p_wr) else $error("revision write wrong");
    property p_lock;
        i_reg_sel && i_reg_wr && i_subsystem_write_lock |=> $stable(o_legacy_revision);
    endproperty
    a_lock: assert property (p_lock) else $error("locked write took");
    property p_bus;
        !i_bus_rstn && !i_reg_sel |=> $stable(o_legacy_revision);
    endproperty
    a_bus: assert property (p_bus) else $error("bus reset hit identity");
    c_old: cover property (o_legacy_mode);
    c_lock: cover property (i_reg_sel && i_reg_wr && i_subsystem_write_lock);
    c_bus: cover property (!i_bus_rstn);
endmodule
bind sir_regs sir_regs_monitor u_mon (.*);
`default_nettype wire

// ==== dv/sir_card.sv ====
/* Card model: pin levels of a card in the socket.
   Assumes the bench sets seating and pin levels. */
`timescale 1ns/100ps
`default_nettype none
module sir_card (
    // Seating and levels
    input wire logic [1:0] i_seat,
    input wire logic [5:0] i_lv,
    // Card pins
    output logic o_cd1,
    output logic o_cd2,
    output logic [5:0] o_pins
);
    // Detect pins pulled high, grounded by a seated card
    assign o_cd1 = ~i_seat[0];
    assign o_cd2 = ~i_seat[1];
    assign o_pins = i_lv;
endmodule
`default_nettype wire

// ==== dv/socket_id_and_status_regs_tb.sv ====
/* Testbench for sir_regs with a card model on the pins.
   Assumes the sir_pkg constants and the one-cycle read answer. */
`timescale 1ns/100ps
`default_nettype none
module socket_id_and_status_regs_tb;
    localparam logic [7:0] ID0 = {sir_pkg::INTERFACE_KIND_VALUE, sir_pkg::EMU_SPARE_RESET,
        sir_pkg::LEGACY_REVISION_RESET};
    logic clk, rstn, brst, sel, wr, lock, pwr, io, rv, lm;
    logic [11:0] addr;
    logic [7:0] wd, rd, e;
    logic [3:0] rev;
    logic [1:0] seat;
    logic [5:0] lv;
    wire logic cd1, cd2;
    wire logic [5:0] p;
    int err_total, checked;
    sir_card u_card (.i_seat(seat), .i_lv(lv), .o_cd1(cd1), .o_cd2(cd2), .o_pins(p));
    sir_regs u_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_bus_rstn(brst), .i_reg_sel(sel),
        .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rd),
        .o_reg_rvalid(rv), .i_subsystem_write_lock(lock), .i_socket_power_on(pwr),
        .i_card_is_io(io), .i_ready_pin(p[5]), .i_card_write_protect_pin(p[4]),
        .i_detect_pin_1(cd1), .i_detect_pin_2(cd2), .i_battery_pin_2(p[3]),
        .i_battery_pin_1(p[2]), .i_speaker_out_pin(p[1]), .i_status_change_pin(p[0]),
        .o_legacy_mode(lm), .o_legacy_revision(rev));
    // Clock
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task chk(input string n, input logic [8:0] s, input logic [8:0] x);
        checked++;
        if (s !== x) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, x, s);
        end
    endtask
    task rdc(input logic [11:0] a, input logic [7:0] x);
        @(posedge clk);
        sel <= 1;
        wr <= 0;
        addr <= a;
        @(posedge clk);
        sel <= 0;
        #1 chk("read", {rv, rd}, {1'b1, x});
    endtask
    task wrt(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        sel <= 1;
        wr <= 1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        sel <= 0;
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #100000 err_total++;
        stop_test;
    end
    // Test sequence
    initial begin
        {rstn, sel, wr, lock, pwr, io, addr, wd, seat, lv} = '0;
        brst = 1;
        repeat (20) @(posedge clk);
        rstn <= 1;
        rdc(12'h800, ID0);
        wrt(12'h800, 8'h32);
        #1 chk("mode", {lm, rev}, 5'h12);
        rdc(12'h800, 8'hb2);
        wrt(12'h800, 8'hff);
        lock <= 1;
        wrt(12'h800, 8'h00);
        rdc(12'h800, 8'hbf);
        @(posedge clk);
        lock <= 0;
        brst <= 0;
        sel <= 1;
        wr <= 0;
        addr <= 12'h800;
        @(posedge clk);
        sel <= 0;
        brst <= 1;
        #1 chk("rvalid", {8'h00, rv}, 9'h000);
        rdc(12'h800, 8'hbf);
        $display("identity test done");
        wrt(12'h801, 8'hff);
        rdc(12'h802, 8'h00);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {io, pwr, seat} <= {i[2], i[0], i[1:0]};
            lv <= {~i[1], i[0], i[1], i[0], ~i[0], i[1]};
            repeat (4) @(posedge clk);
            e = {1'b0, pwr, lv[5:4], seat, io ? lv[1:0] : lv[3:2]};
            rdc(12'h801, e);
        end
        $display("status test done");
        @(posedge clk);
        rstn <= 0;
        pwr <= 0;
        repeat (2) @(posedge clk);
        rstn <= 1;
        repeat (4) @(posedge clk);
        rdc(12'h801, e & 8'h3f);
        rdc(12'h800, ID0);
        $display("reset test done");
        stop_test;
    end
endmodule
`default_nettype wire
